// ===== src/sbc_standby_ctrl.sv
`timescale 1ns/1ns
`include "sbc_cfg.svh"

// How it works
// - light standby: select bits 00 and trigger bit written 1 in normal mode
// - light standby keeps oscillator, pll, flash; gates cpu and peripheral clocks
// - subclock or externally clocked peripherals keep running in light standby
// - ram writes blocked in light standby so contents stay unchanged
// - wake returns to normal next cycle, no stabilisation wait
// - pending unmasked interrupt refuses light standby; cpu just continues
// - nmi, watchdog interrupt, unmasked pin or running peripheral interrupt wakes light
// - any reset source also ends light standby
// - every release returns to normal mode
// - halt: interval timer and watchdog run unless subclock-clocked without subclock
// - halt: watch timer runs on divided main clock, or always with subclock
// - halt: crc runs unless halt came from a crc input register write
// - halt: port outputs and cpu registers hold their entry values
// - halt instruction in normal mode enters halt; oscillator keeps running
// - halt with pending interrupt enters then releases at once
// - maskable wake with interrupts disabled ends standby, request stays unacknowledged
module sbc_standby_ctrl
  import sbc_pkg::*;
#(
  parameter int PIN_N    = 8,
  parameter int PERIPH_N = 4,
  parameter int PORT_W   = 16
) (
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  input  wire logic                halt_exec,
  input  wire logic                crc_halt,
  input  wire logic                save_ctrl_store,
  input  wire logic                standby_trigger_bit,
  input  wire logic                standby_select_hi,
  input  wire logic                standby_select_lo,
  input  wire logic                cpu_int_enable,
  input  wire logic                nmi_pin,
  input  wire logic                watchdog_interrupt,
  input  wire logic [PIN_N-1:0]    external_interrupt_pins,
  input  wire logic [PIN_N-1:0]    ext_int_mask,
  input  wire logic [PERIPH_N-1:0] periph_irq,
  input  wire logic [PERIPH_N-1:0] periph_irq_mask,
  input  wire logic [PERIPH_N-1:0] periph_sub_clocked,
  input  wire logic                reset_pin_n,
  input  wire logic                watchdog_reset,
  input  wire logic                low_voltage_detector,
  input  wire logic                clock_monitor,
  input  wire sbc_cfg_s            cfg,
  input  wire logic [PORT_W-1:0]   port_out_d,
  output sbc_gate_s                gate,
  output logic [PERIPH_N-1:0]      periph_run,
  output logic [PORT_W-1:0]        port_out_q,
  output logic                     cpu_regs_hold,
  output sbc_mode_e                mode,
  output logic                     entry_refused,
  output logic                     wake_pulse,
  output logic                     irq_ack_allow,
  output logic                     irq_retained,
  output logic                     reset_wake
);

  typedef struct packed {
    logic                nmi_s1;
    logic                nmi_s2;
    logic [PIN_N-1:0]    pin_s1;
    logic [PIN_N-1:0]    pin_s2;
    logic                rpin_s1;
    logic                rpin_s2;
    sbc_mode_e           mode;
    logic                crc_entry;
    sbc_gate_s           gate;
    logic [PERIPH_N-1:0] periph_run;
    logic                refused;
    logic                wake;
    logic                ack_allow;
    logic                retained;
    logic                rst_wake;
  } sbc_state_s;

  sbc_state_s state;
  sbc_state_s next_state;

  logic       nmi_wake;
  logic       mask_wake_any;
  logic       mask_wake_light;
  logic       pend_any;
  logic       pend_light;
  logic       rst_src;
  logic       light_req;
  logic [1:0] sel;

  // ==========================================================
  // wake and pending decode, synchronised pins only
  assign sel             = {standby_select_hi, standby_select_lo};
  assign nmi_wake        = state.nmi_s2 | watchdog_interrupt;
  assign mask_wake_light = |(state.pin_s2 & ~ext_int_mask)
                         | |(periph_irq & ~periph_irq_mask & periph_sub_clocked);
  assign mask_wake_any   = |(state.pin_s2 & ~ext_int_mask)
                         | |(periph_irq & ~periph_irq_mask);
  assign pend_any        = nmi_wake | mask_wake_any;
  assign pend_light      = nmi_wake | mask_wake_light;
  assign rst_src         = ~state.rpin_s2 | watchdog_reset
                         | low_voltage_detector | clock_monitor;
  assign light_req       = save_ctrl_store & standby_trigger_bit
                         & (sel == `SBC_SEL_LIGHT);

  // ==========================================================
  // clock gating per mode; only the enables change, never the oscillator
  function automatic sbc_gate_s gates_for(sbc_mode_e m, sbc_cfg_s c, logic crc_e);
    sbc_gate_s g;
    g = '{default: 1'b1};
    case (m)
      SBC_NORMAL: begin
        g = '{default: 1'b1};
      end
      SBC_HALT: begin
        g.cpu_clk_en = 1'b0;
        g.itimer_run = c.subclock_used | ~c.itimer_on_sub;
        g.wdt_run    = c.subclock_used | ~c.wdt_on_sub;
        g.watch_run  = c.subclock_used | c.watch_on_main_div;
        g.crc_run    = ~crc_e;
      end
      SBC_LIGHT: begin
        g.cpu_clk_en    = 1'b0;
        g.periph_clk_en = 1'b0;
        g.dma_run       = 1'b0;
        g.intc_run      = 1'b0; // release decode here stays live
        g.itimer_run    = c.subclock_used & c.itimer_on_sub;
        g.wdt_run       = c.subclock_used & c.wdt_on_sub;
        g.watch_run     = c.subclock_used & ~c.watch_on_main_div;
        g.crc_run       = 1'b0;
        g.ram_write_en  = 1'b0;
      end
      default: begin
        g = '{default: 1'b1};
      end
    endcase
    return g;
  endfunction

  // ==========================================================
  // mode sequencer and registered outputs
  always_comb begin
    next_state           = state;
    next_state.nmi_s1    = nmi_pin;
    next_state.nmi_s2    = state.nmi_s1;
    next_state.pin_s1    = external_interrupt_pins;
    next_state.pin_s2    = state.pin_s1;
    next_state.rpin_s1   = reset_pin_n;
    next_state.rpin_s2   = state.rpin_s1;
    next_state.refused   = 1'b0;
    next_state.wake      = 1'b0;
    next_state.ack_allow = 1'b0;
    next_state.retained  = 1'b0;
    next_state.rst_wake  = 1'b0;
    case (state.mode)
      SBC_NORMAL: begin
        if (halt_exec) begin
          // entered even with a request pending; released next cycle
          next_state.mode      = SBC_HALT;
          next_state.crc_entry = crc_halt;
        end else if (light_req) begin
          if (pend_any) begin
            next_state.refused = 1'b1;
          end else begin
            next_state.mode = SBC_LIGHT;
          end
        end
      end
      SBC_HALT: begin
        if (rst_src || pend_any) begin
          next_state.mode = SBC_NORMAL;
          next_state.wake = 1'b1;
        end
      end
      SBC_LIGHT: begin
        if (rst_src || pend_light) begin
          next_state.mode = SBC_NORMAL;
          next_state.wake = 1'b1;
        end
      end
      default: begin
        next_state.mode = SBC_NORMAL;
      end
    endcase
    // acknowledge status of the wake source
    if (next_state.wake) begin
      next_state.rst_wake  = rst_src;
      next_state.ack_allow = ~rst_src & (nmi_wake | cpu_int_enable);
      next_state.retained  = ~rst_src & ~nmi_wake & ~cpu_int_enable;
    end
    next_state.gate = gates_for(next_state.mode, cfg, next_state.crc_entry);
    if (next_state.mode == SBC_LIGHT) begin
      next_state.periph_run = periph_sub_clocked;
    end else begin
      next_state.periph_run = '1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state            <= '0;
      state.rpin_s1    <= `SBC_RST_PIN_IDLE;
      state.rpin_s2    <= `SBC_RST_PIN_IDLE;
      state.mode       <= SBC_NORMAL;
      state.gate       <= '{default: 1'b1};
      state.periph_run <= '1;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign gate          = state.gate;
  assign periph_run    = state.periph_run;
  assign mode          = state.mode;
  assign cpu_regs_hold = (state.mode != SBC_NORMAL);
  assign entry_refused = state.refused;
  assign wake_pulse    = state.wake;
  assign irq_ack_allow = state.ack_allow;
  assign irq_retained  = state.retained;
  assign reset_wake    = state.rst_wake;

  // port values frozen from the cycle the mode leaves normal
  sbc_hold_reg #(
    .W (PORT_W)
  ) u_port_hold (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .hold     (cpu_regs_hold),
    .d        (port_out_d),
    .q        (port_out_q)
  );

  // ==========================================================
  // checks
  light_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_NORMAL && !halt_exec && light_req && !pend_any
    |=> mode == SBC_LIGHT)
    else $error("light standby not entered");

  light_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_LIGHT |-> !gate.cpu_clk_en && !gate.periph_clk_en
    && gate.osc_run && gate.pll_run && gate.flash_run)
    else $error("wrong gating in light standby");

  sub_periph_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_LIGHT |-> periph_run == $past(periph_sub_clocked))
    else $error("subclocked peripheral stopped");

  ram_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_LIGHT |-> !gate.ram_write_en)
    else $error("ram writable in light standby");

  fast_wake_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_LIGHT && pend_light |=> mode == SBC_NORMAL && wake_pulse
    && gate.cpu_clk_en)
    else $error("light standby wake late");

  refuse_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_NORMAL && !halt_exec && light_req && pend_any
    |=> mode == SBC_NORMAL && entry_refused)
    else $error("entry not refused with pending request");

  reset_wake_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode != SBC_NORMAL && rst_src |=> mode == SBC_NORMAL && reset_wake)
    else $error("reset source did not wake");

  halt_timer_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_HALT |-> gate.itimer_run == ($past(cfg.subclock_used)
    || !$past(cfg.itimer_on_sub)) && gate.watch_run == ($past(cfg.subclock_used)
    || $past(cfg.watch_on_main_div)))
    else $error("timer run flag wrong in halt");

  halt_crc_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_NORMAL && halt_exec |=> mode == SBC_HALT
    && gate.crc_run == !$past(crc_halt) && gate.periph_clk_en && gate.dma_run)
    else $error("halt entry gating wrong");

  halt_pend_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_HALT && pend_any |=> mode == SBC_NORMAL)
    else $error("pending request did not release halt");

  irq_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    mode != SBC_NORMAL && !rst_src && !nmi_wake && !cpu_int_enable
    && ((mode == SBC_HALT && mask_wake_any) || mask_wake_light)
    |=> irq_retained && !irq_ack_allow)
    else $error("disabled maskable wake acknowledged");

  light_cyc_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_NORMAL ##1 mode == SBC_LIGHT ##[1:20] wake_pulse);
  halt_cyc_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    mode == SBC_NORMAL ##1 mode == SBC_HALT ##[1:20] wake_pulse);
  refuse_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    entry_refused);
  rst_wake_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    reset_wake);

endmodule

// ===== src/sbc_cfg.svh
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

// ==========================================================
// standby select encodings
`define SBC_SEL_LIGHT 2'h0

// ==========================================================
// reset values
`define SBC_RST_PIN_IDLE 1'b1
`define SBC_PORT_RST_BIT 1'b0

// ==========================================================
// wake latency: oscillator never stops, so no stabilisation wait
`define SBC_WAKE_WAIT_NS 0

`endif

// ===== src/sbc_pkg.sv
package sbc_pkg;

  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    SBC_NORMAL,
    SBC_HALT,
    SBC_LIGHT
  } sbc_mode_e;

  // ==========================================================
  // static clock-source configuration from the clock generator
  typedef struct packed {
    logic subclock_used;       // subclock oscillator present and running
    logic itimer_on_sub;       // interval timer counts subclock_freq
    logic wdt_on_sub;          // watchdog counts subclock_freq
    logic watch_on_main_div;   // watch timer counts divided main_clock_freq
  } sbc_cfg_s;

  // ==========================================================
  // clock enables and run flags towards the clock tree
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_run;
    logic pll_run;
    logic flash_run;
    logic dma_run;
    logic intc_run;
    logic itimer_run;
    logic wdt_run;
    logic watch_run;
    logic crc_run;
    logic ram_write_en;
  } sbc_gate_s;

endpackage

// ===== src/sbc_hold_reg.sv
`timescale 1ns/1ns
`include "sbc_cfg.svh"

// port output register that freezes while the cpu is stopped
module sbc_hold_reg
  import sbc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         hold,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] val;
  } sbc_hold_s;

  sbc_hold_s state;
  sbc_hold_s next_state;

  // ==========================================================
  // capture path: follows d unless held
  always_comb begin
    next_state = state;
    if (!hold) begin
      next_state.val = d;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{val: {W{`SBC_PORT_RST_BIT}}};
    end else begin
      state <= next_state;
    end
  end

  assign q = state.val;

  // ==========================================================
  // checks
  port_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    hold |=> q == $past(q))
    else $error("port value changed while held");

endmodule

// ===== verif/sbc_fw_model.sv
`timescale 1ns/1ns
// ==========================================================
// firmware side: standby stores and halt instructions
module sbc_fw_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic go_light,
  input  wire logic go_halt,
  input  wire logic trig,
  input  wire logic crc_src,
  output logic      save_ctrl_store,
  output logic      standby_trigger_bit,
  output logic      halt_exec,
  output logic      crc_halt
);
  logic [2:0] nop_cnt;

  // one request, then five idle slots in place of the nops
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      save_ctrl_store <= 1'b0;
      standby_trigger_bit <= 1'b0;
      halt_exec <= 1'b0;
      crc_halt <= 1'b0;
      nop_cnt <= 3'h0;
    end else begin
      save_ctrl_store <= 1'b0;
      halt_exec <= 1'b0;
      // data bits are not valid outside a store, so they wander
      standby_trigger_bit <= ~standby_trigger_bit;
      crc_halt <= ~crc_halt;
      if (nop_cnt != 3'h0) begin
        nop_cnt <= nop_cnt - 3'h1;
      end else if (go_light) begin
        save_ctrl_store <= 1'b1;
        standby_trigger_bit <= trig;
        nop_cnt <= 3'h5;
      end else if (go_halt) begin
        halt_exec <= 1'b1;
        crc_halt <= crc_src;
        nop_cnt <= 3'h5;
      end
    end
  end
endmodule

// ===== verif/tb_standby_clock_gating_control.sv
`timescale 1ns/1ns
// ==========================================================
// bench for the standby clock gating controller
module tb_standby_clock_gating_control
  import sbc_pkg::*;
;
  logic        core_clk, reset_n, go_light, go_halt, trig, crc_src;
  logic        save_ctrl_store, standby_trigger_bit, halt_exec, crc_halt;
  logic        sel_hi, sel_lo, int_en, hold, refused, wake, ack, retained, rwake;
  logic [6:0]  src;
  logic [3:0]  pirq, pirq_mask, prun;
  logic [15:0] pd, pq;
  sbc_cfg_s    cfg;
  sbc_gate_s   gate;
  sbc_mode_e   mode;
  int          fails, comparisons, n;

  // wake sources: nmi, wdt irq, pin 4, wdt reset, lvd, clock monitor, reset pin
  sbc_standby_ctrl DUT (
    .core_clk, .reset_n, .halt_exec, .crc_halt, .save_ctrl_store, .standby_trigger_bit,
    .standby_select_hi(sel_hi), .standby_select_lo(sel_lo), .cpu_int_enable(int_en),
    .nmi_pin(src[0]), .watchdog_interrupt(src[1]),
    .external_interrupt_pins({3'h0, src[2], 4'h0}), .ext_int_mask(8'hEF),
    .periph_irq(pirq), .periph_irq_mask(pirq_mask), .periph_sub_clocked(4'b0101),
    .reset_pin_n(~src[6]), .watchdog_reset(src[3]), .low_voltage_detector(src[4]),
    .clock_monitor(src[5]), .cfg, .port_out_d(pd), .gate, .periph_run(prun),
    .port_out_q(pq), .cpu_regs_hold(hold), .mode, .entry_refused(refused),
    .wake_pulse(wake), .irq_ack_allow(ack), .irq_retained(retained), .reset_wake(rwake)
  );

  sbc_fw_model fw (
    .core_clk, .reset_n, .go_light, .go_halt, .trig, .crc_src, .save_ctrl_store,
    .standby_trigger_bit, .halt_exec, .crc_halt
  );

  // ==========================================================
  // clock and moving port data
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) pd <= pd + 16'h1;

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ask firmware for a request, returns just after the block took it
  task automatic req(input logic l, input logic h);
    @(posedge core_clk);
    go_light <= l;
    go_halt <= h;
    repeat (10) begin
      @(posedge core_clk);
      #1;
      if (save_ctrl_store || halt_exec) break;
    end
    @(posedge core_clk);
    go_light <= 1'b0;
    go_halt <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_light;
    logic [15:0] q0;
    req(1'b1, 1'b0);
    q0 = pq;
    check("mode", mode, SBC_LIGHT);
    check("cpu_periph_clk", {gate.cpu_clk_en, gate.periph_clk_en}, 2'b00);
    check("osc_pll_flash", {gate.osc_run, gate.pll_run, gate.flash_run}, 3'h7);
    check("ram_write_en", gate.ram_write_en, 1'b0);
    check("periph_run", prun, 4'b0101);
    check("cpu_regs_hold", hold, 1'b1);
    // main-clocked and masked requests must not wake
    @(posedge core_clk);
    pirq <= 4'b1010;
    repeat (3) @(posedge core_clk);
    #1;
    check("mode", mode, SBC_LIGHT);
    check("port_out_q", pq, q0);
    @(posedge core_clk);
    pirq <= 4'b0001;
    @(posedge core_clk);
    pirq <= 4'h0;
    #1;
    check("mode", mode, SBC_NORMAL);
    check("gate", gate, 12'hFFF);
    check("periph_run", prun, 4'hF);
    check("retained_ack", {retained, ack}, 2'b10);
    @(posedge core_clk);
    #1;
    check("port_out_q", pq, 16'(pd - 16'h1));
  endtask

  task automatic t_refuse;
    @(posedge core_clk);
    pirq_mask <= 4'h0;
    pirq <= 4'b0010;
    req(1'b1, 1'b0);
    check("entry_refused", refused, 1'b1);
    check("mode", mode, SBC_NORMAL);
    @(posedge core_clk);
    pirq <= 4'h0;
  endtask

  // other select codes, then a store with the trigger clear
  task automatic t_select;
    for (int i = 1; i < 5; i++) begin
      @(posedge core_clk);
      {sel_hi, sel_lo} <= i[1:0];
      trig <= i < 4;
      req(1'b1, 1'b0);
      check("mode", mode, SBC_NORMAL);
      check("entry_refused", refused, 1'b0);
    end
    @(posedge core_clk);
    trig <= 1'b1;
  endtask

  // every clock-source setting, with and without a crc stop
  task automatic t_halt;
    logic [3:0] c;
    for (int i = 0; i < 32; i++) begin
      c = i[3:0];
      @(posedge core_clk);
      cfg <= c;
      crc_src <= i[4];
      req(1'b0, 1'b1);
      check("mode", mode, SBC_HALT);
      check("cpu_clk_en", gate.cpu_clk_en, 1'b0);
      check("others", {gate.periph_clk_en, gate.dma_run, gate.intc_run, gate.osc_run},
            4'hF);
      check("itimer_wdt", {gate.itimer_run, gate.wdt_run}, {c[3] | ~c[2], c[3] | ~c[1]});
      check("watch_run", gate.watch_run, c[3] | c[0]);
      check("crc_run", gate.crc_run, !i[4]);
      check("cpu_regs_hold", hold, 1'b1);
      @(posedge core_clk);
      pirq <= 4'b0100;
      @(posedge core_clk);
      pirq <= 4'h0;
      #1;
      check("mode", mode, SBC_NORMAL);
    end
  endtask

  task automatic t_halt_pend;
    @(posedge core_clk);
    pirq <= 4'b0001;
    req(1'b0, 1'b1);
    check("mode", mode, SBC_HALT);
    @(posedge core_clk);
    pirq <= 4'h0;
    #1;
    check("mode", mode, SBC_NORMAL);
    check("wake_pulse", wake, 1'b1);
  endtask

  // pins and the reset pin pass two synchroniser stages
  task automatic t_wake;
    for (int k = 0; k < 7; k++) begin
      req(1'b1, 1'b0);
      check("mode", mode, SBC_LIGHT);
      @(posedge core_clk);
      src <= 7'h1 << k;
      n = 0;
      do begin
        @(posedge core_clk);
        #1;
        n++;
      end while (mode !== SBC_NORMAL && n < 8);
      check("wake_latency", n, (k == 0 || k == 2 || k == 6) ? 3 : 1);
      check("wake_pulse", wake, 1'b1);
      check("reset_wake", rwake, k > 2);
      if (k < 3) check("irq_ack_allow", ack, 1'b1);
      @(posedge core_clk);
      src <= 7'h0;
      repeat (4) @(posedge core_clk);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {reset_n, go_light, go_halt, crc_src, sel_hi, sel_lo, int_en} = 7'h0;
    trig = 1'b1;
    src = 7'h0;
    pirq = 4'h0;
    pirq_mask = 4'h8;
    cfg = 4'h0;
    pd = 16'h0;
    fails = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check("mode", mode, SBC_NORMAL);
    check("gate", gate, 12'hFFF);
    check("hold_pq", {hold, pq}, {1'b0, 16'(pd - 16'h1)});
    t_light();
    t_refuse();
    t_select();
    t_halt();
    t_halt_pend();
    @(posedge core_clk);
    int_en <= 1'b1;
    t_wake();
    close_out();
  end

  // hang guard, far above the few hundred cycles the run needs
  initial begin
    #20000;
    fails++;
    close_out();
  end
endmodule
